/* File: core/typec_cc_defines.svh */
`ifndef TYPEC_CC_DEFINES_SVH
`define TYPEC_CC_DEFINES_SVH

// Register word addresses (byte addresses, 32-bit aligned).
`define REG_CONTROL 8'h00
`define REG_SWITCHES 8'h04
`define REG_DAC 8'h08
`define REG_STATUS 8'h0C
`define REG_INT_STATUS 8'h10
`define REG_INT_MASK 8'h14

// Control register fields.
`define CTL_SRC_CUR_LSB 0
`define CTL_DAC_VBUS_BIT 2
`define CTL_DISABLED_BIT 3
`define CTL_RESET 32'h0000_0008

// Switch register fields: per pin pull-down, pull-up, vconn.
`define SW_PD1_BIT 0
`define SW_PU1_BIT 1
`define SW_VC1_BIT 2
`define SW_PD2_BIT 3
`define SW_PU2_BIT 4
`define SW_VC2_BIT 5
`define SW_RESET 32'h0000_0000

// Status register fields.
`define ST_LEVEL_LSB 0
`define ST_COMP_BIT 2
`define ST_VBUS_BIT 3
`define ST_ORIENT_BIT 4
`define ST_ATTACH_BIT 5

// Interrupt flag positions.
`define IRQ_LEVEL_BIT 0
`define IRQ_COMP_BIT 1
`define IRQ_VBUS_BIT 2
`define IRQ_WAKE_BIT 3
`define IRQ_ATTACH_BIT 4
`define IRQ_COUNT 5
`define MASK_RESET 32'h0000_0000
`define DAC_RESET 32'h0000_0000

`endif

/* File: core/typec_cc_pkg.sv */
package typec_cc_pkg;
  typedef enum logic [1:0] {
    CUR_OFF = 2'b00,
    CUR_DEFAULT = 2'b01,
    CUR_MID = 2'b10,
    CUR_HIGH = 2'b11
  } src_cur_e;
endpackage

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a group of asynchronous comparator levels.
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
  } sync_s;
  sync_s st_ff;
  sync_s nxt_st;

  always_comb begin
    nxt_st.meta_ff = i_async;
    nxt_st.sync_ff = st_ff.meta_ff;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.sync_ff;
endmodule // pin_sync
`default_nettype wire

/* File: core/typec_cc_detect_status.sv */
// Contract
// [R01] Watch both CC pins before attach to find attach and orientation.
// [R02] As host, present the selected charging current on the active CC pin.
// [R03] As host, use CC state to notice partner removal.
// [R04] As device, report the current level advertised by the host on CC.
// [R05] As upstream port, use VBUS valid to decide attach or detach.
// [R06] Route VCONN onto the CC pin not used for configuration.
// [R07] Drive the open-drain interrupt low to ask software to read status.
// [R08] Each CC pin has independent pull-down, pull-up and VCONN switches.
// [R09] Sample three fixed CC comparators; any change raises the level interrupt. Here only a change in the level code of the higher pin does.
// [R10] Provide a 6-bit software DAC threshold and its comparator result.
// [R11] Report VBUS valid comparator and flag its changes.
// [R12] DAC comparator selectable onto VBUS for software checks.
// [R13] Software classifies Ra or Rd from level bits and DAC result.
// [R14] Source current setting applies at once, and at attach if set before.
// [R15] When disabled without termination, any CC activity raises a wake interrupt.
// [R16] Synchronise comparators; interrupt flags stay latched until software clears them.
// [R17] Release interrupt only when no unmasked flag remains set.
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "typec_cc_defines.svh"
module typec_cc_detect_status (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Classic Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Analog front end: per pin fixed comparators (thermometer, 3 bits each).
  input wire logic [2:0] i_cc1_level_cmp,
  input wire logic [2:0] i_cc2_level_cmp,
  input wire logic i_cc1_activity,
  input wire logic i_cc2_activity,
  input wire logic i_dac_cmp,
  input wire logic i_vbus_valid_cmp,
  // Termination and DAC controls, and the interrupt output.
  output logic o_cc1_pull_down,
  output logic o_cc2_pull_down,
  output logic o_cc1_pull_up,
  output logic o_cc2_pull_up,
  output logic [1:0] o_cc1_source_current,
  output logic [1:0] o_cc2_source_current,
  output logic o_cc1_vconn,
  output logic o_cc2_vconn,
  output logic [5:0] o_dac_level,
  output logic o_dac_on_vbus,
  output logic o_int_n_oe
);
  typedef struct packed {
    logic [3:0] control_ff;
    logic [5:0] switches_ff;
    logic [5:0] dac_ff;
    logic [`IRQ_COUNT-1:0] flags_ff;
    logic [`IRQ_COUNT-1:0] mask_ff;
    logic [1:0] level_prev_ff;
    logic comp_prev_ff;
    logic vbus_prev_ff;
    logic attach_prev_ff;
    logic orient_ff;
    logic [1:0] cur1_ff;
    logic [1:0] cur2_ff;
    logic vc1_ff;
    logic vc2_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic int_oe_ff;
  } regs_s;

  regs_s st_ff;
  regs_s nxt_st;

  logic [9:0] async_in;
  logic [9:0] sync_in;
  logic [2:0] lvl1;
  logic [2:0] lvl2;
  logic act1;
  logic act2;
  logic comp;
  logic vbus_ok;

  assign async_in = {i_vbus_valid_cmp, i_dac_cmp, i_cc2_activity, i_cc1_activity,
                     i_cc2_level_cmp, i_cc1_level_cmp};

  pin_sync #(
    .WIDTH(10)
  ) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(async_in),
    .o_sync(sync_in)
  ); // R16

  assign lvl1 = sync_in[2:0];
  assign lvl2 = sync_in[5:3];
  assign act1 = sync_in[6];
  assign act2 = sync_in[7];
  assign comp = sync_in[8];
  assign vbus_ok = sync_in[9];

  // Thermometer code to 2-bit level.
  function automatic logic [1:0] therm2bin(input logic [2:0] t);
    logic [1:0] r;
    r = 2'h0;
    if (t[2]) begin
      r = 2'h3;
    end else if (t[1]) begin
      r = 2'h2;
    end else if (t[0]) begin
      r = 2'h1;
    end
    return r;
  endfunction

  logic [1:0] code1;
  logic [1:0] code2;
  logic orient_now;
  logic [1:0] cc_level_bits;
  logic attached;
  logic is_host;
  logic is_sink;
  logic disabled;
  logic access;
  logic [`IRQ_COUNT-1:0] events;
  logic [31:0] rd_mux;
  logic [31:0] wmask;

  always_comb begin
    code1 = therm2bin(lvl1);
    code2 = therm2bin(lvl2);
    // The pin with the higher level carries the connection; ties favour CC1.
    orient_now = (code2 > code1); // R01
    cc_level_bits = orient_now ? code2 : code1; // R04
    is_host = st_ff.switches_ff[`SW_PU1_BIT] | st_ff.switches_ff[`SW_PU2_BIT];
    is_sink = st_ff.switches_ff[`SW_PD1_BIT] | st_ff.switches_ff[`SW_PD2_BIT];
    disabled = st_ff.control_ff[`CTL_DISABLED_BIT];
    // A sink is attached by VBUS; a host by a pull-down seen on either pin.
    if (is_sink && !is_host) begin
      attached = vbus_ok; // R05
    end else begin
      attached = (code1 != 2'h0) | (code2 != 2'h0); // R03
    end
  end

  always_comb begin
    events = '0;
    events[`IRQ_LEVEL_BIT] = (cc_level_bits != st_ff.level_prev_ff); // R09
    events[`IRQ_COMP_BIT] = (comp != st_ff.comp_prev_ff); // R10
    events[`IRQ_VBUS_BIT] = (vbus_ok != st_ff.vbus_prev_ff); // R11
    events[`IRQ_WAKE_BIT] = disabled && (st_ff.switches_ff == 6'h00) && (act1 | act2); // R15
    events[`IRQ_ATTACH_BIT] = (attached != st_ff.attach_prev_ff); // R01
  end

  always_comb begin
    wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    rd_mux = 32'h0000_0000;
    case (i_wb_adr)
      `REG_CONTROL: rd_mux = {28'h0000000, st_ff.control_ff};
      `REG_SWITCHES: rd_mux = {26'h0000000, st_ff.switches_ff};
      `REG_DAC: rd_mux = {26'h0000000, st_ff.dac_ff};
      `REG_STATUS: rd_mux = {26'h0000000, attached, st_ff.orient_ff, vbus_ok, comp,
                             cc_level_bits}; // R13
      `REG_INT_STATUS: rd_mux = {27'h0000000, st_ff.flags_ff};
      `REG_INT_MASK: rd_mux = {27'h0000000, st_ff.mask_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    access = i_wb_cyc && i_wb_stb && !st_ff.ack_ff;
    nxt_st.ack_ff = access;
    nxt_st.rdata_ff = access ? rd_mux : st_ff.rdata_ff;
    nxt_st.level_prev_ff = cc_level_bits;
    nxt_st.comp_prev_ff = comp;
    nxt_st.vbus_prev_ff = vbus_ok;
    nxt_st.attach_prev_ff = attached;
    // Orientation is frozen while attached so noise on the far pin cannot flip it.
    // The previous attach state is used so the first attached cycle still latches the pin.
    if (!st_ff.attach_prev_ff) begin
      nxt_st.orient_ff = orient_now; // R01
    end
    if (access && i_wb_we) begin
      case (i_wb_adr)
        `REG_CONTROL: nxt_st.control_ff = 4'((st_ff.control_ff & ~wmask[3:0]) |
                                              (i_wb_dat[3:0] & wmask[3:0]));
        `REG_SWITCHES: nxt_st.switches_ff = 6'((st_ff.switches_ff & ~wmask[5:0]) |
                                                (i_wb_dat[5:0] & wmask[5:0])); // R08
        `REG_DAC: nxt_st.dac_ff = 6'((st_ff.dac_ff & ~wmask[5:0]) |
                                      (i_wb_dat[5:0] & wmask[5:0])); // R10
        `REG_INT_MASK: nxt_st.mask_ff = 5'((st_ff.mask_ff & ~wmask[4:0]) |
                                            (i_wb_dat[4:0] & wmask[4:0]));
        default: nxt_st.mask_ff = st_ff.mask_ff;
      endcase
    end
    // Read clears the flags; an event in the same cycle still sets its flag.
    if (access && !i_wb_we && i_wb_adr == `REG_INT_STATUS) begin
      nxt_st.flags_ff = events; // R16
    end else begin
      nxt_st.flags_ff = st_ff.flags_ff | events; // R16
    end
    // Source current follows the selection continuously, so a change after
    // attach shows at once and one made before attach is already in place.
    nxt_st.cur1_ff = st_ff.switches_ff[`SW_PU1_BIT] ?
                     st_ff.control_ff[`CTL_SRC_CUR_LSB +: 2] : 2'h0; // R02 R14
    nxt_st.cur2_ff = st_ff.switches_ff[`SW_PU2_BIT] ?
                     st_ff.control_ff[`CTL_SRC_CUR_LSB +: 2] : 2'h0; // R02 R14
    // VCONN only ever goes to the pin opposite the configuration pin.
    nxt_st.vc1_ff = st_ff.switches_ff[`SW_VC1_BIT] && nxt_st.orient_ff && attached; // R06
    nxt_st.vc2_ff = st_ff.switches_ff[`SW_VC2_BIT] && !nxt_st.orient_ff && attached; // R06
    nxt_st.int_oe_ff = |(nxt_st.flags_ff & ~st_ff.mask_ff); // R07 R17
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_ff <= '0;
      st_ff.control_ff <= 4'(`CTL_RESET);
      st_ff.switches_ff <= 6'(`SW_RESET);
      st_ff.mask_ff <= 5'(`MASK_RESET);
      st_ff.dac_ff <= 6'(`DAC_RESET);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_wb_dat = st_ff.rdata_ff;
  assign o_wb_ack = st_ff.ack_ff;
  assign o_cc1_pull_down = st_ff.switches_ff[`SW_PD1_BIT]; // R08
  assign o_cc2_pull_down = st_ff.switches_ff[`SW_PD2_BIT]; // R08
  assign o_cc1_pull_up = st_ff.switches_ff[`SW_PU1_BIT]; // R08
  assign o_cc2_pull_up = st_ff.switches_ff[`SW_PU2_BIT]; // R08
  assign o_cc1_source_current = st_ff.cur1_ff;
  assign o_cc2_source_current = st_ff.cur2_ff;
  assign o_cc1_vconn = st_ff.vc1_ff;
  assign o_cc2_vconn = st_ff.vc2_ff;
  assign o_dac_level = st_ff.dac_ff;
  assign o_dac_on_vbus = st_ff.control_ff[`CTL_DAC_VBUS_BIT]; // R12
  assign o_int_n_oe = st_ff.int_oe_ff; // R07
endmodule // typec_cc_detect_status
`default_nettype wire

/* File: tb/typec_cc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module typec_cc_monitor (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic o_cc1_pull_up,
  input wire logic o_cc2_pull_up,
  input wire logic [1:0] o_cc1_source_current,
  input wire logic [1:0] o_cc2_source_current,
  input wire logic o_cc1_vconn,
  input wire logic o_cc2_vconn,
  input wire logic o_int_n_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_ack_once: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_ack_due: assert property (i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_stb)) else $error("ack unasked");
  a_ack_idle: assert property (!i_wb_stb [*2] |-> !o_wb_ack) else $error("ack idle");
  // The current code lags the pull-up by one cycle, so only a settled pull-up is judged.
  a_src1_off:
    assert property (!o_cc1_pull_up [*2] |-> o_cc1_source_current == 2'h0) else $error("cur1");
  a_src2_off:
    assert property (!o_cc2_pull_up [*2] |-> o_cc2_source_current == 2'h0) else $error("cur2");
  a_vconn_one: assert property (!(o_cc1_vconn && o_cc2_vconn)) else $error("vconn");
  // Flags clear only by a read and are masked only by a mask write, both of which are acknowledged.
  a_int_clear:
    assert property ($fell(o_int_n_oe) |-> o_wb_ack || $past(o_wb_ack)) else $error("int dropped");
endmodule // typec_cc_monitor
bind typec_cc_detect_status typec_cc_monitor i_typec_cc_monitor (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .o_cc1_pull_up(o_cc1_pull_up), .o_cc2_pull_up(o_cc2_pull_up), .o_int_n_oe(o_int_n_oe),
  .o_cc1_source_current(o_cc1_source_current), .o_cc2_source_current(o_cc2_source_current),
  .o_cc1_vconn(o_cc1_vconn), .o_cc2_vconn(o_cc2_vconn));
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_clock,
  input wire logic i_wb_ack,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_int_n_oe,
  output var logic o_wb_cyc = 1'b0,
  output var logic o_wb_stb = 1'b0,
  output var logic o_wb_we = 1'b0,
  output var logic [7:0] o_wb_adr = 8'h00,
  output var logic [31:0] o_wb_dat = 32'h0000_0000,
  output logic o_int_n
);
  assign o_int_n = !i_int_n_oe;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge i_clock);
    o_wb_cyc <= 1'b1;
    o_wb_stb <= 1'b1;
    o_wb_we <= w;
    o_wb_adr <= a;
    o_wb_dat <= d;
    do @(posedge i_clock); while (i_wb_ack !== 1'b1);
    q = i_wb_dat;
    o_wb_cyc <= 1'b0;
    o_wb_stb <= 1'b0;
    // Released lines flip so a stale address or word never passes for a live one.
    o_wb_adr <= ~a;
    o_wb_dat <= ~d;
  endtask
endmodule // host_model
`default_nettype wire

/* File: tb/typec_cc_detect_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "typec_cc_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module typec_cc_detect_status_bench;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] i_cc1_level_cmp = 3'h0;
  logic [2:0] i_cc2_level_cmp = 3'h0;
  logic i_cc2_activity = 1'b0;
  logic i_dac_cmp = 1'b0;
  logic i_vbus_valid_cmp = 1'b0;
  logic i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_cc1_pull_down, o_cc2_pull_down, int_n;
  logic o_cc1_pull_up, o_cc2_pull_up, o_cc1_vconn, o_cc2_vconn, o_dac_on_vbus, o_int_n_oe;
  logic [7:0] i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  logic [1:0] o_cc1_source_current, o_cc2_source_current;
  logic [5:0] o_dac_level;
  int n_errors = 0;
  int n_tests = 0;
  always #10 i_clock = ~i_clock;
  typec_cc_detect_status i_typec_cc_detect_status (.i_clock, .i_sys_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel(4'hF), .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_cc1_level_cmp,
    .i_cc2_level_cmp, .i_cc1_activity(1'b0), .i_cc2_activity, .i_dac_cmp,
    .i_vbus_valid_cmp, .o_cc1_pull_down, .o_cc2_pull_down, .o_cc1_pull_up, .o_cc2_pull_up,
    .o_cc1_source_current, .o_cc2_source_current, .o_cc1_vconn, .o_cc2_vconn, .o_dac_level,
    .o_dac_on_vbus, .o_int_n_oe);
  host_model i_host_model (.i_clock, .i_wb_ack(o_wb_ack), .i_wb_dat(o_wb_dat),
    .i_int_n_oe(o_int_n_oe), .o_wb_cyc(i_wb_cyc), .o_wb_stb(i_wb_stb), .o_wb_we(i_wb_we),
    .o_wb_adr(i_wb_adr), .o_wb_dat(i_wb_dat), .o_int_n(int_n));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_host_model.xfer(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask
  // Fixed waits cover the two synchroniser flops, the flag and the output register.
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_sink();
    rd(`REG_CONTROL, `CTL_RESET);
    wr(`REG_CONTROL, 32'h0000_0000);
    wr(`REG_SWITCHES, 32'h0000_0009);
    idle(2);
    `CHK({o_cc1_pull_down, o_cc1_pull_up, o_cc2_pull_down, o_cc2_pull_up}, 4'hA)
    i_vbus_valid_cmp <= 1'b1;
    idle(8);
    `CHK(int_n, 1'b0)
    rd(`REG_STATUS, 32'h0000_0028);
    rd(`REG_INT_STATUS, 32'h0000_0014);
    rd(8'hFC, 32'h0000_0000);
    `CHK(int_n, 1'b1)
    wr(`REG_INT_MASK, 32'h0000_001F);
    i_vbus_valid_cmp <= 1'b0;
    idle(8);
    `CHK(int_n, 1'b1)
    wr(`REG_INT_MASK, 32'h0000_0000);
    idle(2);
    `CHK(int_n, 1'b0)
    rd(`REG_INT_STATUS, 32'h0000_0014);
    $display("sink test over");
  endtask
  task automatic t_source();
    wr(`REG_SWITCHES, 32'h0000_0012);
    wr(`REG_CONTROL, 32'(typec_cc_pkg::CUR_HIGH));
    idle(3);
    `CHK(o_cc1_source_current, typec_cc_pkg::CUR_HIGH)
    i_cc1_level_cmp <= 3'h1;
    idle(8);
    rd(`REG_INT_STATUS, 32'h0000_0011);
    wr(`REG_CONTROL, 32'h0000_0005);
    wr(`REG_SWITCHES, 32'h0000_0032);
    wr(`REG_DAC, 32'h0000_003D);
    idle(3);
    `CHK(o_cc1_source_current, typec_cc_pkg::CUR_DEFAULT)
    `CHK({o_cc1_vconn, o_cc2_vconn}, 2'h1)
    `CHK({o_dac_on_vbus, o_dac_level}, 7'h7D)
    i_dac_cmp <= 1'b1;
    idle(8);
    rd(`REG_INT_STATUS, 32'h0000_0002);
    $display("source test over");
  endtask
  task automatic t_wake();
    wr(`REG_SWITCHES, 32'h0000_0000);
    wr(`REG_CONTROL, `CTL_RESET);
    i_cc2_activity <= 1'b1;
    idle(8);
    i_host_model.xfer(1'b0, `REG_INT_STATUS, 32'h0000_0000, q);
    `CHK(q[`IRQ_WAKE_BIT], 1'b1)
    $display("wake test over");
  endtask
  task automatic t_flip();
    i_cc1_level_cmp <= 3'h0;
    idle(8);
    i_cc2_level_cmp <= 3'h7;
    idle(8);
    rd(`REG_STATUS, 32'h0000_0037);
    `CHK(int_n, 1'b0)
    $display("flip test over");
  endtask
  initial begin
    idle(3);
    i_sys_rst <= 1'b0;
    t_sink();
    t_source();
    t_wake();
    t_flip();
    end_of_test();
  end
  initial begin
    idle(3000);
    n_errors++;
    end_of_test();
  end
endmodule // typec_cc_detect_status_bench
`default_nettype wire
